// [hw/mpm_cfg.svh]
`ifndef MPM_CFG_SVH
`define MPM_CFG_SVH

// Register addresses
`define MPM_ADDR_RXDRV_LO 16'h0100
`define MPM_ADDR_RXDRV_HI 16'h0101
`define MPM_ADDR_FUNC_BASE 16'h0102
`define MPM_ADDR_PIN_LEVEL 16'h0109
`define MPM_ADDR_VALIDATE 16'h2002
`define MPM_ADDR_FAULT 16'h2003
`define MPM_ADDR_IRQ_CLEAR 16'h2005

// Function register fields
`define MPM_FUNC_OE_BIT 7
`define MPM_FUNC_RESET 8'h00
`define MPM_RXDRV_RESET 2'h0
`define MPM_RXDRV_PER_REG 4

// Control function codes
`define MPM_CODE_IRQ_BASE 7'h10
`define MPM_CODE_FAULT_BASE 7'h20
`define MPM_CODE_VALID_END_BASE 7'h28
`define MPM_CODE_TDC_BASE 7'h30

// Status code groups: code divided by four
`define MPM_GRP_EEPROM 5'h03
`define MPM_GRP_IRQ 5'h04
`define MPM_GRP_DEMOD_LO 5'h05
`define MPM_GRP_DEMOD_HI 5'h06
`define MPM_GRP_RESYNC 5'h07
`define MPM_GRP_FAULTED 5'h08
`define MPM_GRP_VALID 5'h09
`define MPM_GRP_ACTIVE 5'h0A
`define MPM_GRP_AUX 5'h0B
`define MPM_GRP_LOOP 5'h0C

// Status source bit positions
`define MPM_EEPROM_FAULT_BIT_A 2
`define MPM_EEPROM_FAULT_BIT_B 3
`define MPM_TEMP_ALARM_BIT 0
`define MPM_REF_FAULTED_BIT 3
`define MPM_REF_VALID_BIT 4
`define MPM_LOOP_PHASE_LOCK_BIT 1
`define MPM_LOOP_FREQ_LOCK_BIT 2
`define MPM_ALOOP_LOCK_BIT 3

`endif

// [hw/mpm_pkg.sv]
`default_nettype none

package mpm_pkg;
  typedef logic [6:0] mpm_code_t;
  typedef logic [7:0] mpm_byte_t;
  // Receiver/driver field: control use picks the Boolean, status the drive
  typedef enum logic [1:0] {
    MPM_DRV_AND = 2'h0,
    MPM_DRV_NAND = 2'h1,
    MPM_DRV_OR = 2'h2,
    MPM_DRV_NOR = 2'h3
  } mpm_drv_e;
endpackage : mpm_pkg

`default_nettype wire

// [hw/mpm_pin_if.sv]
`default_nettype none

interface mpm_pin_if #(parameter int N = 7);
  logic [N-1:0] level;
  logic [N-1:0] is_ctrl;
  mpm_pkg::mpm_code_t code [N];
  mpm_pkg::mpm_drv_e drv [N];
  modport source (output level, output is_ctrl, output code, output drv);
  modport sink (input level, input is_ctrl, input code, input drv);
endinterface : mpm_pin_if

`default_nettype wire

// [hw/mpm_combiner.sv]
`default_nettype none

module mpm_combiner #(
  parameter int N = 7,
  parameter mpm_pkg::mpm_code_t FUNC_CODE = 7'h00
) (
  mpm_pin_if.sink pins,
  output logic result
);
  logic any_sel;
  logic any_or;
  logic or_val;
  logic and_val;
  logic lvl;

  always_comb begin
    any_sel = 1'b0;
    any_or = 1'b0;
    or_val = 1'b0;
    and_val = 1'b1;
    lvl = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (pins.is_ctrl[i] && pins.code[i] == FUNC_CODE) begin
        any_sel = 1'b1;
        // Low bit of the field inverts the pin
        lvl = pins.level[i] ^ pins.drv[i][0];
        if (pins.drv[i][1]) begin
          any_or = 1'b1;
          or_val = or_val | lvl; // RQ3
        end else begin
          and_val = and_val & lvl; // RQ3
        end
      end
    end
    // OR group folds to one term, then ANDs with the rest
    result = any_sel && and_val && (or_val || !any_or); // RQ3
  end
endmodule : mpm_combiner

`default_nettype wire

// [hw/mpm_pin_map.sv]
// Functional notes
// (RQ1) Output-enable bit clear means control pin
// (RQ2) Seven-bit code picks each pin's function
// (RQ3) OR pins combine first, then AND
// (RQ4) Code 0x0C: EEPROM fault, D2 or D3
// (RQ5) Code 0x0D: temperature alarm, bit D0
// (RQ6) Code 0x10: clear all / any event
// (RQ7) Code 0x11: common events clear / summary
// (RQ8) Code 0x12: channel-0 events clear / summary
// (RQ9) Code 0x13: channel-1 events clear / summary
// (RQ10) Codes 0x1C-0x1F: reference divider resync
// (RQ11) Codes 0x20-0x23 control: force reference fault
// (RQ12) Codes 0x20-0x23 status: reference faulted flag
// (RQ13) Codes 0x24-0x27: reference valid flag
// (RQ14) Codes 0x28-0x2B: validate reference only if faulted
// (RQ15) Codes 0x28-0x2B status: reference active
// (RQ16) Codes 0x2C-0x2D: auxiliary oscillator active
// (RQ17) Code 0x30: digitizer 0 / phase lock
// (RQ18) Code 0x31: digitizer 1 / frequency lock
// (RQ19) Code 0x32: ping-pong digitizer / loop zero lock
// (RQ20) Unassigned codes: ignore input, deassert output
// (RQ21) Pin acts like software setting proxy bit
// (RQ22) Clock-like status passes without status registers
`include "mpm_cfg.svh"
`default_nettype none

module mpm_pin_map #(
  parameter int N = 7,
  parameter int IRQ_W = 8
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [N-1:0] multifunction_pin_in,
  output logic [N-1:0] multifunction_pin_out,
  output logic [N-1:0] multifunction_pin_oe,
  input wire logic [7:0] eeprom_status,
  input wire logic [7:0] temp_status,
  input wire logic [IRQ_W-1:0] irq_common_events,
  input wire logic [IRQ_W-1:0] irq_loop_zero_events,
  input wire logic [IRQ_W-1:0] irq_loop_one_events,
  input wire logic [3:0] reference_demod_clk,
  input wire logic [3:0] reference_resync,
  input wire logic [3:0][7:0] reference_status,
  input wire logic [3:0] reference_active,
  input wire logic [1:0] auxiliary_numeric_oscillator_active,
  input wire logic [1:0] feedback_active,
  input wire logic [7:0] channel_zero_loop_status,
  output logic [3:0] irq_clear_req,
  output logic [3:0] reference_fault_force,
  output logic [3:0] reference_validate_end,
  output logic [2:0] time_interval_digitizer_in
);
  localparam int NFUNC = 15;

  logic rst_meta;
  logic rst_n;
  logic [N-1:0] pin_meta;
  logic [N-1:0] pin_sync;
  mpm_pkg::mpm_byte_t func_reg [N];
  mpm_pkg::mpm_drv_e drv_reg [N];
  logic [3:0] sw_fault;
  logic [3:0] sw_irq_clear;
  logic [3:0] sw_validate;
  logic [NFUNC-1:0] func_result;
  logic [N-1:0] next_pin_out;
  logic [N-1:0] next_pin_oe;
  logic [N-1:0] pin_status;
  logic [7:0] next_rdata;
  logic [7:0] rxdrv_lo;
  logic [7:0] rxdrv_hi;

  mpm_pin_if #(.N(N)) pins ();

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  // Reset release is not gated by clk_en so the block always leaves reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (clk_en) begin
      pin_meta <= multifunction_pin_in;
      pin_sync <= pin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  for (genvar p = 0; p < N; p++) begin : g_cfg
    localparam logic [15:0] FADDR = 16'(`MPM_ADDR_FUNC_BASE + p);
    localparam logic [15:0] RADDR = (p < `MPM_RXDRV_PER_REG) ?
      `MPM_ADDR_RXDRV_LO : `MPM_ADDR_RXDRV_HI;
    localparam int RLSB = 2 * (p % `MPM_RXDRV_PER_REG);

    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        func_reg[p] <= `MPM_FUNC_RESET;
        drv_reg[p] <= mpm_pkg::mpm_drv_e'(`MPM_RXDRV_RESET);
      end else if (clk_en && reg_wr) begin
        if (reg_addr == FADDR) begin
          func_reg[p] <= reg_wdata; // RQ2
        end
        if (reg_addr == RADDR) begin
          drv_reg[p] <= mpm_pkg::mpm_drv_e'(reg_wdata[RLSB +: 2]);
        end
      end
    end

    assign pins.level[p] = pin_sync[p];
    assign pins.is_ctrl[p] = !func_reg[p][`MPM_FUNC_OE_BIT]; // RQ1
    assign pins.code[p] = func_reg[p][6:0]; // RQ2
    assign pins.drv[p] = drv_reg[p];
  end

  // Fault forcing is a level; clear and validate bits self-clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_fault <= 4'h0;
    end else if (clk_en && reg_wr && reg_addr == `MPM_ADDR_FAULT) begin
      sw_fault <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_irq_clear <= 4'h0;
      sw_validate <= 4'h0;
    end else if (clk_en) begin
      sw_irq_clear <= (reg_wr && reg_addr == `MPM_ADDR_IRQ_CLEAR) ?
        reg_wdata[3:0] : 4'h0;
      sw_validate <= (reg_wr && reg_addr == `MPM_ADDR_VALIDATE) ?
        reg_wdata[3:0] : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  always_comb begin
    rxdrv_lo = 8'h00;
    rxdrv_hi = 8'h00;
    for (int p = 0; p < N; p++) begin
      if (p < `MPM_RXDRV_PER_REG) begin
        rxdrv_lo[2*p +: 2] = drv_reg[p];
      end else if (p < 2 * `MPM_RXDRV_PER_REG) begin
        rxdrv_hi[2*(p-`MPM_RXDRV_PER_REG) +: 2] = drv_reg[p];
      end
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      `MPM_ADDR_RXDRV_LO: next_rdata = rxdrv_lo;
      `MPM_ADDR_RXDRV_HI: next_rdata = rxdrv_hi;
      `MPM_ADDR_FAULT: next_rdata = {4'h0, sw_fault};
      `MPM_ADDR_PIN_LEVEL: next_rdata = 8'(pin_sync);
      default: begin
        for (int p = 0; p < N; p++) begin
          if (reg_addr == 16'(`MPM_ADDR_FUNC_BASE + p)) begin
            next_rdata = func_reg[p];
          end
        end
      end
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control functions

  // One combiner per assigned control code; others have none, so
  // control pins on unassigned codes reach nothing
  for (genvar f = 0; f < NFUNC; f++) begin : g_func
    localparam mpm_pkg::mpm_code_t CODE =
      (f < 4) ? 7'(`MPM_CODE_IRQ_BASE + f) :
      (f < 8) ? 7'(`MPM_CODE_FAULT_BASE + f - 4) :
      (f < 12) ? 7'(`MPM_CODE_VALID_END_BASE + f - 8) :
      7'(`MPM_CODE_TDC_BASE + f - 12); // RQ20
    mpm_combiner #(.N(N), .FUNC_CODE(CODE)) u_comb (
      .pins(pins.sink),
      .result(func_result[f])
    );
  end

  // Pin and software requests merge so either has the same effect
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_clear_req <= 4'h0;
    end else if (clk_en) begin
      irq_clear_req <= func_result[3:0] | sw_irq_clear; // RQ6 RQ7 RQ8 RQ9 RQ21
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reference_fault_force <= 4'h0;
    end else if (clk_en) begin
      reference_fault_force <= func_result[7:4] | sw_fault; // RQ11 RQ21
    end
  end

  // Validation only acts on a faulted reference
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reference_validate_end <= 4'h0;
    end else if (clk_en) begin
      for (int r = 0; r < 4; r++) begin
        reference_validate_end[r] <= (func_result[8+r] | sw_validate[r]) &
          reference_status[r][`MPM_REF_FAULTED_BIT]; // RQ14 RQ21
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      time_interval_digitizer_in <= 3'h0;
    end else if (clk_en) begin
      time_interval_digitizer_in <= func_result[14:12]; // RQ17 RQ18 RQ19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status functions

  function automatic logic status_pick(input mpm_pkg::mpm_code_t c);
    logic s;
    s = 1'b0;
    case (c[6:2])
      `MPM_GRP_EEPROM: begin
        if (c[1:0] == 2'h0) begin
          s = eeprom_status[`MPM_EEPROM_FAULT_BIT_A] |
            eeprom_status[`MPM_EEPROM_FAULT_BIT_B]; // RQ4
        end else if (c[1:0] == 2'h1) begin
          s = temp_status[`MPM_TEMP_ALARM_BIT]; // RQ5
        end
      end
      `MPM_GRP_IRQ: begin
        case (c[1:0])
          2'h0: s = |{irq_common_events, irq_loop_zero_events,
            irq_loop_one_events}; // RQ6
          2'h1: s = |irq_common_events; // RQ7
          2'h2: s = |irq_loop_zero_events; // RQ8
          default: s = |irq_loop_one_events; // RQ9
        endcase
      end
      // Clock-like sources go straight to the pin flop
      `MPM_GRP_DEMOD_LO, `MPM_GRP_DEMOD_HI: begin
        if (!c[0]) begin
          s = reference_demod_clk[{~c[2], c[1]}]; // RQ22
        end
      end
      `MPM_GRP_RESYNC: s = reference_resync[c[1:0]]; // RQ10
      `MPM_GRP_FAULTED: begin
        s = reference_status[c[1:0]][`MPM_REF_FAULTED_BIT]; // RQ12
      end
      `MPM_GRP_VALID: begin
        s = reference_status[c[1:0]][`MPM_REF_VALID_BIT]; // RQ13
      end
      `MPM_GRP_ACTIVE: s = reference_active[c[1:0]]; // RQ15
      `MPM_GRP_AUX: begin
        s = c[1] ? feedback_active[c[0]] : // RQ22
          auxiliary_numeric_oscillator_active[c[0]]; // RQ16
      end
      `MPM_GRP_LOOP: begin
        case (c[1:0])
          2'h0: s = channel_zero_loop_status[`MPM_LOOP_PHASE_LOCK_BIT]; // RQ17
          2'h1: s = channel_zero_loop_status[`MPM_LOOP_FREQ_LOCK_BIT]; // RQ18
          2'h2: s = channel_zero_loop_status[`MPM_ALOOP_LOCK_BIT]; // RQ19
          default: s = 1'b0; // RQ20
        endcase
      end
      default: s = 1'b0; // RQ20
    endcase
    return s;
  endfunction : status_pick

  // Driver mode per pin; open-drain modes release the pin when idle
  for (genvar p = 0; p < N; p++) begin : g_out
    always_comb begin
      pin_status[p] = status_pick(pins.code[p]);
      next_pin_out[p] = 1'b0;
      next_pin_oe[p] = 1'b0;
      if (!pins.is_ctrl[p]) begin // RQ1
        case (drv_reg[p])
          mpm_pkg::MPM_DRV_AND: begin
            next_pin_out[p] = pin_status[p];
            next_pin_oe[p] = 1'b1;
          end
          mpm_pkg::MPM_DRV_NAND: begin
            next_pin_out[p] = !pin_status[p];
            next_pin_oe[p] = 1'b1;
          end
          mpm_pkg::MPM_DRV_OR: begin
            next_pin_out[p] = 1'b1;
            next_pin_oe[p] = pin_status[p];
          end
          default: begin
            next_pin_out[p] = 1'b0;
            next_pin_oe[p] = pin_status[p];
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      multifunction_pin_out <= '0;
      multifunction_pin_oe <= '0;
    end else if (clk_en) begin
      multifunction_pin_out <= next_pin_out;
      multifunction_pin_oe <= next_pin_oe;
    end
  end
endmodule : mpm_pin_map

`default_nettype wire

// [tb/mpm_pin_map_monitor.sv]
`default_nettype none
module mpm_pin_map_monitor #(
  parameter int N = 7
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [N-1:0] multifunction_pin_in,
  input wire logic [N-1:0] multifunction_pin_out,
  input wire logic [N-1:0] multifunction_pin_oe,
  input wire logic [7:0] eeprom_status,
  input wire logic [7:0] temp_status,
  input wire logic [3:0][7:0] reference_status,
  input wire logic [7:0] channel_zero_loop_status,
  input wire logic [3:0] irq_clear_req,
  input wire logic [3:0] reference_fault_force,
  input wire logic [3:0] reference_validate_end
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Shadow of pin 0 setup, so checks know which source is routed
  logic [7:0] f0;
  logic [1:0] d0;
  logic [3:0] flt;
  assign flt = {reference_status[3][3], reference_status[2][3],
    reference_status[1][3], reference_status[0][3]};
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      f0 <= 8'h00;
      d0 <= 2'h0;
    end else if (reg_wr && clk_en) begin
      if (reg_addr == 16'h0102) f0 <= reg_wdata;
      if (reg_addr == 16'h0100) d0 <= reg_wdata[1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  eeprom_fault_a: assert property (
    f0 == 8'h8C && d0 == 2'h0 |=> multifunction_pin_out[0] ==
    ($past(eeprom_status[2]) | $past(eeprom_status[3])))
    else $error("eeprom fault pin wrong");
  temp_alarm_low_a: assert property (
    f0 == 8'h8D && d0 == 2'h1 |=>
    multifunction_pin_out[0] == !$past(temp_status[0]))
    else $error("inverted alarm pin wrong");
  phase_lock_a: assert property (
    f0 == 8'hB0 && d0 == 2'h2 |=> multifunction_pin_out[0] &&
    multifunction_pin_oe[0] == $past(channel_zero_loop_status[1]))
    else $error("phase lock open drain pin wrong");
  unassigned_quiet_a: assert property (
    f0 == 8'h8E && d0 == 2'h0 |=> multifunction_pin_out[0] == 1'b0)
    else $error("unassigned code drives pin");
  rdata_idle_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  clear_pulse_a: assert property (
    clk_en && reg_wr && reg_addr == 16'h2005 && reg_wdata[1] |->
    ##2 irq_clear_req[1])
    else $error("common clear missing");
  validate_gate_a: assert property (
    (reference_validate_end & ~$past(flt)) == 4'h0)
    else $error("validate on unfaulted reference");
  force_pin_a: assert property (
    (f0 == 8'h20 && d0 == 2'h0 && multifunction_pin_in[0]) [*5] |->
    reference_fault_force[0])
    else $error("pin fault force missing");
endmodule : mpm_pin_map_monitor

bind mpm_pin_map mpm_pin_map_monitor #(.N(N)) u_mon (.core_clk, .resetn,
  .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .multifunction_pin_in, .multifunction_pin_out, .multifunction_pin_oe,
  .eeprom_status, .temp_status, .reference_status, .channel_zero_loop_status,
  .irq_clear_req, .reference_fault_force, .reference_validate_end);
`default_nettype wire

// [tb/mpm_host_model.sv]
`default_nettype none
module mpm_host_model #(
  parameter int N = 7
) (
  input wire logic [N-1:0] want,
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe,
  output logic [N-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driving pin wins; host only drives pins the device has released
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & want);
endmodule : mpm_host_model
`default_nettype wire

// [tb/test_multifunction_pin_code_map.sv]
`default_nettype none
module test_multifunction_pin_code_map;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic clk_en = 1'b1;
  logic [95:0] src = 96'h0;
  logic [6:0] want = 7'h00;
  logic [7:0] reg_rdata;
  logic [6:0] pin_in, pin_out, pin_oe;
  logic [3:0] irq_clr, flt_frc, val_end;
  logic [2:0] tdc_in;
  logic [31:0] rng = 32'h3;
  int num_errors = 0;
  int total_checks = 0;

  mpm_pin_map #(.N(7), .IRQ_W(8)) uut (.core_clk, .resetn, .clk_en,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .multifunction_pin_in(pin_in), .multifunction_pin_out(pin_out),
    .multifunction_pin_oe(pin_oe), .eeprom_status(src[7:0]),
    .temp_status(src[15:8]), .irq_common_events(src[23:16]),
    .irq_loop_zero_events(src[31:24]), .irq_loop_one_events(src[39:32]),
    .reference_demod_clk(src[43:40]), .reference_resync(src[47:44]),
    .reference_status(src[79:48]), .reference_active(src[83:80]),
    .auxiliary_numeric_oscillator_active(src[85:84]),
    .feedback_active(src[87:86]), .channel_zero_loop_status(src[95:88]),
    .irq_clear_req(irq_clr), .reference_fault_force(flt_frc),
    .reference_validate_end(val_end), .time_interval_digitizer_in(tdc_in));
  mpm_host_model #(.N(7)) host (.want, .pin_out, .pin_oe, .pin_in);

  initial begin
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  // Status model: source bit, then drive mode
  function automatic logic [1:0] st_exp(input int c, input int d);
    logic s;
    s = 1'b0;
    if (c == 12) s = src[2] | src[3];
    if (c == 13) s = src[8];
    if (c == 16) s = |src[39:16];
    if (c >= 17 && c <= 19) s = |src[8 * c - 120 +: 8];
    if (c >= 20 && c <= 26 && c % 2 == 0) s = src[30 + c / 2];
    if (c >= 28 && c <= 31) s = src[c + 16];
    if (c >= 32 && c <= 35) s = src[8 * c - 205];
    if (c >= 36 && c <= 39) s = src[8 * c - 236];
    if (c >= 40 && c <= 47) s = src[c + 40];
    if (c >= 48) s = src[c + 41];
    case (d)
      0: return {1'b1, s};
      1: return {1'b1, ~s};
      2: return {s, 1'b1};
      default: return {s, 1'b0};
    endcase
  endfunction : st_exp

  // Control model: {digitizer, validate, fault, irq clear}
  function automatic logic [14:0] ctl_exp(input int c, input int l);
    logic [14:0] e;
    e = 15'h0;
    if (c >= 16 && c <= 19) e[c - 16] = l[0];
    if (c >= 32 && c <= 35) e[c - 28] = l[0];
    if (c >= 40 && c <= 43) e[c - 32] = l[0] & src[8 * c - 269];
    if (c >= 48) e[c - 36] = l[0];
    return e;
  endfunction : ctl_exp

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(16'(reg_rdata), 16'(e));
  endtask : rd

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  // Whole run is about 1700 cycles; about six times that means a hang
  initial begin
    #40000;
    num_errors++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk(16'(pin_oe), 16'h0000);
    for (int p = 0; p < 7; p++) begin
      rd(16'h0102 + 16'(p), 8'h00);
    end
    $display("reset test done");
    for (int c = 12; c <= 50; c++) begin
      for (int d = 0; d < 4; d++) begin
        @(posedge core_clk);
        src <= {xs(), xs(), xs()};
        wr(16'h0100, 8'(d));
        wr(16'h0102, 8'h80 | 8'(c));
        @(posedge core_clk);
        #1;
        chk(16'({pin_oe[0], pin_out[0]}), 16'(st_exp(c, d)));
        rd(16'h0102, 8'h80 | 8'(c));
      end
    end
    $display("status code test done");
    @(posedge core_clk);
    src <= {xs(), xs(), xs()};
    wr(16'h0100, 8'h00);
    for (int c = 12; c <= 50; c++) begin
      wr(16'h0102, 8'(c));
      for (int l = 0; l < 2; l++) begin
        @(posedge core_clk);
        want <= 7'(l);
        repeat (3) @(posedge core_clk);
        #1;
        chk(16'({tdc_in, val_end, flt_frc, irq_clr}), 16'(ctl_exp(c, l)));
      end
    end
    $display("control code test done");
    // Pin 0 AND, pin 1 NOT OR, pin 2 OR, all on fault of reference one
    wr(16'h0100, 8'h2C);
    for (int p = 0; p < 3; p++) begin
      wr(16'h0102 + 16'(p), 8'h21);
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      want <= 7'(i);
      repeat (3) @(posedge core_clk);
      #1;
      chk(16'(flt_frc[1]), 16'({(~i[1] | i[2]) & i[0]}));
    end
    @(posedge core_clk);
    want <= 7'h00;
    for (int p = 0; p < 3; p++) begin
      wr(16'h0102 + 16'(p), 8'h00);
    end
    $display("combine test done");
    wr(16'h2003, 8'h05);
    rd(16'h2003, 8'h05);
    chk(16'(flt_frc), 16'h0005);
    wr(16'h2005, 8'h0F);
    @(posedge core_clk);
    #1;
    chk(16'(irq_clr), 16'h000F);
    wr(16'h2002, 8'h0F);
    @(posedge core_clk);
    #1;
    chk(16'(val_end), 16'({src[75], src[67], src[59], src[51]}));
    rd(16'h2002, 8'h00);
    rd(16'h0200, 8'h00);
    rd(16'h0100, 8'h2C);
    // Frozen clock enable must drop the write
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(16'h2003, 8'h0A);
    clk_en <= 1'b1;
    rd(16'h2003, 8'h05);
    $display("software proxy test done");
    end_sim();
  end
endmodule : test_multifunction_pin_code_map
`default_nettype wire
